// File: logic/drive_event_regs.svh
// register offsets, status bit positions and reset values for the drive event capture
`ifndef DRIVE_EVENT_REGS_SVH
`define DRIVE_EVENT_REGS_SVH

// ********************
// register indexes
// ********************
`define STICKY_EVENT_STATUS_IDX 16'h2180
`define LATCHED_EVENT_STATUS_IDX 16'h2181

// ********************
// status word bit positions
// ********************
`define BIT_TRACK_ERR 5'h00
`define BIT_TRACK_WARN 5'h01
`define BIT_IN_RESET 5'h02
`define BIT_POS_WRAP 5'h03
`define BIT_FAULT 5'h04
`define BIT_VEL_LIMIT 5'h05
`define BIT_ACC_LIMIT 5'h06
`define BIT_MOVE_DONE 5'h07
`define BIT_VEL_WIN 5'h08
`define BIT_PHASE_UNINIT 5'h09

// ********************
// reset values
// ********************
`define EVENT_RESET 32'h00000000
`define SETTLE_CNT_RESET 16'h0000

`endif

// File: logic/drive_event_pkg.sv
// types shared by the drive event capture
package drive_event_pkg;
    typedef logic [31:0] word_t;
    typedef logic [15:0] index_t;
    typedef enum logic [1:0] {
        MV_IDLE = 2'b00,
        MV_RUN = 2'b01,
        MV_SETTLE = 2'b11,
        MV_DONE = 2'b10
    } move_state_t;
endpackage : drive_event_pkg

// File: logic/drive_event_status_capture.sv
// status word builder plus sticky and latched event registers for the drive
`timescale 1ns/100ps
`include "drive_event_regs.svh"

// Overview of operation
// - sticky register is read-only, 32 bits, same layout as live status word
// - sticky bit shows live bit was set at any time since last read
// - reading sticky register clears all bits not set in the live word that cycle
// - writes to sticky register are ignored
// - latched bits stay set until software clears them; reads do not clear
// - tracking error set while position error is outside tracking window
// - motion done set after trajectory ends and error settles in window
// - motion done holds until a new trajectory starts
// - velocity window bit set when absolute velocity error exceeds window
// - position wrapped bit set when position counter rolls over
// - phase not initialized bit set until algorithmic phasing completes
// - reset condition bit set while drive is held in reset
// - velocity and acceleration limit bits, plus fault bit
// - fault bit set while FAULT_I is high; the fault cause is not stored
// - latched bits set by events, cleared by software clear or by reset
// - write to latched register clears bits written one, keeps zeros
module drive_event_status_capture (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // object dictionary access
    input wire drive_event_pkg::index_t IDX_I,
    input wire logic RD_I,
    input wire logic WR_I,
    input wire drive_event_pkg::word_t WDATA_I,
    output drive_event_pkg::word_t RDATA_O,
    // drive conditions
    input wire logic [31:0] POS_ERR_I,
    input wire logic [31:0] TRACK_WIN_I,
    input wire logic [31:0] TRACK_WARN_WIN_I,
    input wire logic [31:0] VEL_ERR_I,
    input wire logic [31:0] VEL_WIN_I,
    input wire logic [15:0] SETTLE_CYC_I,
    input wire logic TRAJ_START_I,
    input wire logic TRAJ_END_I,
    input wire logic POS_WRAP_I,
    input wire logic PHASE_DONE_I,
    input wire logic DRIVE_IN_RESET_I,
    input wire logic VEL_LIMIT_I,
    input wire logic ACC_LIMIT_I,
    input wire logic FAULT_I,
    // live status
    output drive_event_pkg::word_t STATUS_O
);
    import drive_event_pkg::*;

    // ********************
    // live status word
    // ********************
    logic [31:0] abs_pos_err;
    logic [31:0] abs_vel_err;
    logic in_window;
    word_t live;
    move_state_t mv_q, mv_d;
    logic [15:0] settle_q, settle_d;

    always_comb begin
        abs_pos_err = POS_ERR_I[31] ? (~POS_ERR_I + 32'h00000001) : POS_ERR_I;
        abs_vel_err = VEL_ERR_I[31] ? (~VEL_ERR_I + 32'h00000001) : VEL_ERR_I;
        in_window = (abs_pos_err <= TRACK_WIN_I);
        live = `EVENT_RESET;
        live[`BIT_TRACK_ERR] = ~in_window;
        live[`BIT_TRACK_WARN] = (abs_pos_err > TRACK_WARN_WIN_I);
        live[`BIT_IN_RESET] = DRIVE_IN_RESET_I;
        live[`BIT_POS_WRAP] = POS_WRAP_I;
        live[`BIT_FAULT] = FAULT_I;
        live[`BIT_VEL_LIMIT] = VEL_LIMIT_I;
        live[`BIT_ACC_LIMIT] = ACC_LIMIT_I;
        live[`BIT_MOVE_DONE] = (mv_q == MV_DONE);
        live[`BIT_VEL_WIN] = (abs_vel_err > VEL_WIN_I);
        live[`BIT_PHASE_UNINIT] = ~PHASE_DONE_I;
    end

    // ********************
    // motion done tracking
    // ********************
    // a new start beats everything, so done never survives a fresh trajectory
    always_comb begin
        mv_d = mv_q;
        settle_d = settle_q;
        case (mv_q)
            MV_IDLE: begin
                if (TRAJ_START_I) mv_d = MV_RUN;
            end
            MV_RUN: begin
                if (TRAJ_END_I) begin
                    mv_d = MV_SETTLE;
                    settle_d = `SETTLE_CNT_RESET;
                end
            end
            MV_SETTLE: begin
                // error leaving the window restarts the settling time
                if (!in_window) settle_d = `SETTLE_CNT_RESET;
                else if (settle_q >= SETTLE_CYC_I) mv_d = MV_DONE;
                else settle_d = settle_q + 16'h0001;
            end
            MV_DONE: begin
                mv_d = MV_DONE;
            end
            default: mv_d = MV_IDLE;
        endcase
        if (TRAJ_START_I) begin
            mv_d = MV_RUN;
            settle_d = `SETTLE_CNT_RESET;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mv_q <= MV_IDLE;
            settle_q <= `SETTLE_CNT_RESET;
        end else begin
            mv_q <= mv_d;
            settle_q <= settle_d;
        end
    end

    // ********************
    // event registers
    // ********************
    word_t sticky_q, sticky_d;
    word_t latched_q, latched_d;
    word_t rdata_q, rdata_d;
    word_t status_q;
    logic rd_sticky, rd_latched, wr_latched;

    always_comb begin
        rd_sticky = RD_I && (IDX_I == `STICKY_EVENT_STATUS_IDX);
        rd_latched = RD_I && (IDX_I == `LATCHED_EVENT_STATUS_IDX);
        wr_latched = WR_I && (IDX_I == `LATCHED_EVENT_STATUS_IDX);
        // write to the sticky index falls through untouched
        sticky_d = (rd_sticky ? `EVENT_RESET : sticky_q) | live;
        latched_d = (wr_latched ? (latched_q & ~WDATA_I) : latched_q) | live;
        rdata_d = rdata_q;
        if (rd_sticky) rdata_d = sticky_q;
        else if (rd_latched) rdata_d = latched_q;
        else if (RD_I) rdata_d = `EVENT_RESET;
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sticky_q <= `EVENT_RESET;
            latched_q <= `EVENT_RESET;
            rdata_q <= `EVENT_RESET;
            status_q <= `EVENT_RESET;
        end else begin
            sticky_q <= sticky_d;
            latched_q <= latched_d;
            rdata_q <= rdata_d;
            status_q <= live;
        end
    end

    assign RDATA_O = rdata_q;
    assign STATUS_O = status_q;

    // ********************
    // checks
    // ********************
    property p_sticky_clear;
        @(posedge CLK_I) disable iff (!RST_N_I)
        rd_sticky |=> (sticky_q == $past(live));
    endproperty
    a_sticky_clear: assert property (p_sticky_clear) else $error("sticky not cleared by read");

    property p_sticky_rdata;
        @(posedge CLK_I) disable iff (!RST_N_I)
        rd_sticky |=> (RDATA_O == $past(sticky_q));
    endproperty
    a_sticky_rdata: assert property (p_sticky_rdata) else $error("sticky read data wrong");

    property p_sticky_wr_ignored;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (WR_I && IDX_I == `STICKY_EVENT_STATUS_IDX && !RD_I) |=>
            (sticky_q == ($past(sticky_q) | $past(live)));
    endproperty
    a_sticky_wr_ignored: assert property (p_sticky_wr_ignored) else $error("sticky changed by write");

    property p_latched_read_keeps;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (rd_latched && !WR_I) |=> ((latched_q & $past(latched_q)) == $past(latched_q));
    endproperty
    a_latched_read_keeps: assert property (p_latched_read_keeps) else $error("latched lost on read");

    property p_latched_w1c;
        @(posedge CLK_I) disable iff (!RST_N_I)
        wr_latched |=> (latched_q == (($past(latched_q) & ~$past(WDATA_I)) | $past(live)));
    endproperty
    a_latched_w1c: assert property (p_latched_w1c) else $error("latched write-one-clear wrong");

    property p_event_not_lost;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (live != `EVENT_RESET) |=> (((sticky_q & $past(live)) == $past(live))
            && ((latched_q & $past(live)) == $past(live)));
    endproperty
    a_event_not_lost: assert property (p_event_not_lost) else $error("event lost on clear");

    property p_track_err;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (abs_pos_err > TRACK_WIN_I) |=> STATUS_O[`BIT_TRACK_ERR];
    endproperty
    a_track_err: assert property (p_track_err) else $error("tracking error bit missing");

    property p_done_cleared;
        @(posedge CLK_I) disable iff (!RST_N_I)
        TRAJ_START_I |=> !live[`BIT_MOVE_DONE] ##1 !STATUS_O[`BIT_MOVE_DONE];
    endproperty
    a_done_cleared: assert property (p_done_cleared) else $error("done not cleared by start");

    property p_done_holds;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (mv_q == MV_DONE && !TRAJ_START_I) |=> (mv_q == MV_DONE);
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("done dropped early");

    property p_vel_win;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (abs_vel_err > VEL_WIN_I) |=> STATUS_O[`BIT_VEL_WIN];
    endproperty
    a_vel_win: assert property (p_vel_win) else $error("velocity window bit missing");

endmodule : drive_event_status_capture

// File: test/drive_host.sv
// host model issuing object dictionary reads and writes
`timescale 1ns/100ps
module drive_host (
    // clock
    input wire logic clk_i,
    // access
    output drive_event_pkg::index_t idx_o,
    output logic rd_o,
    output logic wr_o,
    output drive_event_pkg::word_t wdata_o,
    input wire drive_event_pkg::word_t rdata_i
);
    import drive_event_pkg::*;
    initial begin
        idx_o = 16'h0000;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 32'h00000000;
    end
    // idle lines show the inverse so no stale index looks selected
    task automatic rd(input index_t idx, output word_t d);
        @(posedge clk_i);
        #1;
        idx_o = idx;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        idx_o = ~idx;
        d = rdata_i;
    endtask : rd
    task automatic wr(input index_t idx, input word_t d);
        @(posedge clk_i);
        #1;
        idx_o = idx;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        idx_o = ~idx;
        wdata_o = ~d;
    endtask : wr
endmodule : drive_host

// File: test/tb.sv
// self-checking bench for the drive event capture
`timescale 1ns/100ps
`include "drive_event_regs.svh"
module tb;
    import drive_event_pkg::*;
    localparam index_t STK = `STICKY_EVENT_STATUS_IDX;
    localparam index_t LAT = `LATCHED_EVENT_STATUS_IDX;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    index_t idx;
    logic rd, wr;
    word_t wdata, rdata, status, got, exp_l, m;
    logic [31:0] pos_err = 32'h0, vel_err = 32'h0;
    logic t_start = 1'b0, t_end = 1'b0, wrap = 1'b0, ph_done = 1'b1;
    logic in_rst = 1'b0, vel_lim = 1'b0, acc_lim = 1'b0, fault = 1'b0;
    integer seed = 32'hCA45C4FE;
    int num_errors = 0, total_checks = 0, n;
    always #4 clk = ~clk;
    drive_event_status_capture dut (.CLK_I(clk), .RST_N_I(rst_n), .IDX_I(idx), .RD_I(rd),
        .WR_I(wr), .WDATA_I(wdata), .RDATA_O(rdata), .POS_ERR_I(pos_err),
        .TRACK_WIN_I(32'h64), .TRACK_WARN_WIN_I(32'hC8), .VEL_ERR_I(vel_err),
        .VEL_WIN_I(32'h32), .SETTLE_CYC_I(16'h3), .TRAJ_START_I(t_start), .TRAJ_END_I(t_end),
        .POS_WRAP_I(wrap), .PHASE_DONE_I(ph_done), .DRIVE_IN_RESET_I(in_rst),
        .VEL_LIMIT_I(vel_lim), .ACC_LIMIT_I(acc_lim), .FAULT_I(fault), .STATUS_O(status));
    drive_host host (.clk_i(clk), .idx_o(idx), .rd_o(rd), .wr_o(wr), .wdata_o(wdata),
        .rdata_i(rdata));
    // ********************
    // helpers
    // ********************
    task automatic chk(input word_t g, input word_t e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    function automatic word_t ev(input logic [4:0] b);
        return word_t'(b) << `BIT_IN_RESET;
    endfunction : ev
    task automatic cond(input word_t p, input word_t v, input logic ph, input word_t e);
        pos_err = p;
        vel_err = v;
        ph_done = ph;
        step(3);
        chk(status & 32'h00000303, e);
    endtask : cond
    // raises the velocity limit for exactly the edge that the next access is taken on
    task automatic pulse_vel;
        @(posedge clk);
        #1;
        vel_lim = 1'b1;
        step(1);
        vel_lim = 1'b0;
    endtask : pulse_vel
    // ********************
    // main sequence
    // ********************
    initial begin
        step(16);
        rst_n = 1'b1;
        step(2);
        chk(status, 32'h0);
        host.rd(STK, got);
        chk(got, 32'h0);
        host.rd(LAT, got);
        chk(got, 32'h0);
        host.rd(16'h2182, got);
        chk(got, 32'h0);
        cond(32'h65, 32'h0, 1'b1, 32'h1);
        cond(32'hC9, 32'h0, 1'b1, 32'h3);
        cond(-32'h65, 32'h0, 1'b1, 32'h1);
        cond(32'h64, 32'h0, 1'b1, 32'h0);
        cond(32'h0, -32'h33, 1'b1, 32'h100);
        cond(32'h0, 32'h32, 1'b1, 32'h0);
        cond(32'h0, 32'h0, 1'b0, 32'h200);
        cond(32'h0, 32'h0, 1'b1, 32'h0);
        host.rd(STK, got);
        chk(got, 32'h303);
        t_start = 1'b1;
        step(1);
        t_start = 1'b0;
        t_end = 1'b1;
        step(1);
        t_end = 1'b0;
        step(1);
        chk(status & 32'h80, 32'h0);
        n = 0;
        // bounded wait: the settle count is short, so 40 cycles is ample
        while (status[`BIT_MOVE_DONE] !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        // settle count 3 needs 4 in-window cycles, then status lags one more edge
        chk(word_t'(n), 32'h4);
        if (n >= 40) close_out();
        step(8);
        chk(status & 32'h80, 32'h80);
        t_start = 1'b1;
        step(1);
        t_start = 1'b0;
        step(2);
        chk(status & 32'h80, 32'h0);
        host.rd(STK, got);
        host.wr(LAT, 32'hFFFFFFFF);
        exp_l = 32'h0;
        for (int i = 0; i < 24; i++) begin
            m = $random(seed);
            step(1);
            {acc_lim, vel_lim, fault, wrap, in_rst} = m[4:0];
            step(1);
            {acc_lim, vel_lim, fault, wrap, in_rst} = 5'h0;
            exp_l = exp_l | ev(m[4:0]);
            host.wr(STK, 32'hFFFFFFFF);
            host.rd(STK, got);
            chk(got, ev(m[4:0]));
            host.rd(STK, got);
            chk(got, 32'h0);
            host.rd(LAT, got);
            chk(got, exp_l);
            m = $random(seed);
            host.wr(LAT, m);
            exp_l = exp_l & ~m;
            host.rd(LAT, got);
            chk(got, exp_l);
        end
        // the event lands only on the edge that takes the clearing access
        fork
            host.rd(STK, got);
            pulse_vel();
        join
        host.rd(STK, got);
        chk(got, 32'h20);
        fork
            host.wr(LAT, 32'hFFFFFFFF);
            pulse_vel();
        join
        host.rd(LAT, got);
        chk(got, 32'h20);
        // mid-run reset while a latched bit stands
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(2);
        chk(status, 32'h0);
        host.rd(STK, got);
        chk(got, 32'h0);
        host.rd(LAT, got);
        chk(got, 32'h0);
        close_out();
    end
endmodule : tb
